//--- core/fod_cdr.sv
// Purpose: Oversampled clock and data recovery, 16 clocks per bit
// Assumes: din is on this clock, one sample per cycle
// Notes: Hard alignment while acquiring, one-step nudges afterwards
`timescale 1ns/1ps
`default_nettype none
`include "fod_cfg.svh"
module fod_cdr (
  input wire logic clock,
  input wire logic rst,
  input wire logic enable,
  input wire logic din,
  output logic bit_val,
  output logic bit_stb,
  output logic synced
);
  import fod_pkg::*;
  logic [3:0] ph_r;
  logic [2:0] edges_r;
  logic din_d_r;
  logic edge_w;

  assign edge_w = enable && (din != din_d_r);

  always_ff @(posedge clock) begin
    if (rst) din_d_r <= 1'b0;
    else din_d_r <= din;
  end

  // One step per transition covers a 3% rate offset with margin
  always_ff @(posedge clock) begin
    if (rst || !enable) ph_r <= 4'h0;
    else if (edge_w && !synced) ph_r <= 4'h1;
    else if (edge_w && ph_r != 4'h0 && !ph_r[3]) ph_r <= ph_r;
    else if (edge_w && ph_r[3]) ph_r <= ph_r + 4'h2;
    else ph_r <= ph_r + 4'h1;
  end

  always_ff @(posedge clock) begin
    if (rst || !enable) edges_r <= 3'h0;
    else if (edge_w && edges_r != `FOD_CDR_ACQ_EDGES) edges_r <= edges_r + 3'h1;
  end

  always_ff @(posedge clock) begin
    if (rst || !enable) synced <= 1'b0;
    else synced <= (edges_r == `FOD_CDR_ACQ_EDGES);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      bit_stb <= 1'b0;
      bit_val <= 1'b0;
    end else begin
      bit_stb <= enable && (ph_r == `FOD_CDR_HALF);
      if (enable && ph_r == `FOD_CDR_HALF) bit_val <= din;
    end
  end
endmodule : fod_cdr
`default_nettype wire

//--- core/fod_cfg.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: Registers sit at their printed offsets on a 10-bit address
// Notes: Fields are given as bit ranges for direct part-selects
`ifndef FOD_CFG_SVH
`define FOD_CFG_SVH
`define FOD_A_DISC_BW 10'h10F
`define FOD_A_POSTF 10'h110
`define FOD_A_PHASE 10'h112
`define FOD_A_GLOCK 10'h113
`define FOD_A_DEMOD 10'h115
`define FOD_A_FLOCK 10'h116
`define FOD_A_GAINS 10'h117
`define FOD_A_PREQ 10'h11B
`define FOD_A_AGCCLK 10'h35B
`define FOD_A_FERR 10'h372
`define FOD_RST_DISC_BW 8'h00
`define FOD_RST_POSTF 8'h10
`define FOD_RST_PHASE 8'h00
`define FOD_RST_GLOCK 8'h00
`define FOD_RST_DEMOD 8'h00
`define FOD_RST_FLOCK 8'h00
`define FOD_RST_GAINS 8'h73
`define FOD_RST_PREQ 8'h80
`define FOD_RST_AGCCLK 8'h00
`define FOD_F_PHASE 1:0
`define FOD_F_GLOCK 1:0
`define FOD_F_DEMOD 1:0
`define FOD_F_INTERMEDIATE_FILTER_WIDTH 7:6
`define FOD_F_LOCK 1:0
`define FOD_F_KI 7:4
`define FOD_F_KP 3:0
`define FOD_B_PRE_EN 7
`define FOD_F_ACQ 3:0
`define FOD_F_TRK 7:4
`define FOD_PULL_100 9'h032
`define FOD_PULL_150 9'h04B
`define FOD_PULL_200 9'h064
`define FOD_PULL_300 9'h096
`define FOD_CDR_HALF 4'h8
`define FOD_CDR_ACQ_EDGES 3'h5
`define FOD_SYNC_WAIT_BITS 6'h20
`endif

//--- core/fod_demod_ctrl.sv
// Purpose: Receive baseband control: filter, AFC, lock, OOK slicer, CDR
// Assumes: Status inputs come from logic on this same clock
// Notes: Registers sit at their printed offsets, read data one cycle late
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "fod_cfg.svh"
module fod_demod_ctrl (
  input wire logic clock,
  input wire logic rst,
  input wire logic [9:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic signed [7:0] disc_sample,
  input wire logic [7:0] rssi_level,
  input wire logic in_receive,
  input wire logic enter_receive_command,
  input wire logic sport_mode,
  input wire logic preamble_found,
  input wire logic preamble_done,
  input wire logic sync_found,
  input wire logic packet_done,
  output logic signed [8:0] lo_offset_khz,
  output logic afc_locked,
  output logic corr_enable,
  output logic ook_enable,
  output logic [7:0] discriminator_bandwidth,
  output logic [1:0] discriminator_phase_select,
  output logic [7:0] ook_threshold,
  output logic [3:0] gain_clk_div,
  output logic gain_acquiring,
  output logic rx_bit,
  output logic rx_bit_strobe,
  output logic bit_synced,
  output logic signed [7:0] filt_out
);
  import fod_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Configuration registers

  logic [7:0] disc_bw_r;
  logic [7:0] postf_r;
  logic [7:0] phase_r;
  logic [7:0] glock_r;
  logic [7:0] demod_r;
  logic [7:0] flock_r;
  logic [7:0] gains_r;
  logic [7:0] preq_r;
  logic [7:0] agcclk_r;
  logic [7:0] ferr_r;

  always_ff @(posedge clock) begin
    if (rst) begin
      disc_bw_r <= `FOD_RST_DISC_BW;
      postf_r <= `FOD_RST_POSTF;
      phase_r <= `FOD_RST_PHASE;
      glock_r <= `FOD_RST_GLOCK;
      demod_r <= `FOD_RST_DEMOD;
      flock_r <= `FOD_RST_FLOCK;
      gains_r <= `FOD_RST_GAINS;
      preq_r <= `FOD_RST_PREQ;
      agcclk_r <= `FOD_RST_AGCCLK;
    end else if (reg_wr) begin
      case (reg_addr)
        `FOD_A_DISC_BW: disc_bw_r <= reg_wdata;
        `FOD_A_POSTF: postf_r <= reg_wdata;
        `FOD_A_PHASE: phase_r <= reg_wdata;
        `FOD_A_GLOCK: glock_r <= reg_wdata;
        `FOD_A_DEMOD: demod_r <= reg_wdata;
        `FOD_A_FLOCK: flock_r <= reg_wdata;
        `FOD_A_GAINS: gains_r <= reg_wdata;
        `FOD_A_PREQ: preq_r <= reg_wdata;
        `FOD_A_AGCCLK: agcclk_r <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Read data stand only in the cycle after the strobe; unmapped reads 0
  always_ff @(posedge clock) begin
    if (rst || !reg_rd) reg_rdata <= 8'h00;
    else begin
      case (reg_addr)
        `FOD_A_DISC_BW: reg_rdata <= disc_bw_r;
        `FOD_A_POSTF: reg_rdata <= postf_r;
        `FOD_A_PHASE: reg_rdata <= phase_r;
        `FOD_A_GLOCK: reg_rdata <= glock_r;
        `FOD_A_DEMOD: reg_rdata <= demod_r;
        `FOD_A_FLOCK: reg_rdata <= flock_r;
        `FOD_A_GAINS: reg_rdata <= gains_r;
        `FOD_A_PREQ: reg_rdata <= preq_r;
        `FOD_A_AGCCLK: reg_rdata <= agcclk_r;
        `FOD_A_FERR: reg_rdata <= ferr_r;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode decode

  fod_afc_mode_t afc_mode;
  logic is_corr;
  logic is_ook;
  logic pre_en;
  logic [3:0] ki;
  logic [3:0] kp;
  logic [8:0] pull_limit;

  // Wider IF filter admits a wider pull-in
  function automatic logic [8:0] pull_range(input logic [1:0] intermediate_filter_width);
    case (intermediate_filter_width)
      2'h0: pull_range = `FOD_PULL_100;
      2'h1: pull_range = `FOD_PULL_150;
      2'h2: pull_range = `FOD_PULL_200;
      default: pull_range = `FOD_PULL_300;
    endcase
  endfunction : pull_range

  // Coarse log2 map: wider bandwidth means a smaller shift, faster pole
  function automatic logic [2:0] bw_shift(input logic [7:0] bw);
    if (bw[7:6] != 2'h0) bw_shift = 3'h1;
    else if (bw[5:4] != 2'h0) bw_shift = 3'h2;
    else if (bw[3:2] != 2'h0) bw_shift = 3'h3;
    else if (bw[1] != 1'b0) bw_shift = 3'h4;
    else if (bw[0] != 1'b0) bw_shift = 3'h5;
    else bw_shift = 3'h7;
  endfunction : bw_shift

  assign afc_mode = fod_afc_mode_t'(flock_r[`FOD_F_LOCK]);
  assign is_corr = (demod_r[`FOD_F_DEMOD] == 2'h0);
  assign is_ook = (demod_r[`FOD_F_DEMOD] == 2'h2);
  assign pre_en = preq_r[`FOD_B_PRE_EN];
  assign ki = gains_r[`FOD_F_KI];
  assign kp = gains_r[`FOD_F_KP];
  assign pull_limit = pull_range(demod_r[`FOD_F_INTERMEDIATE_FILTER_WIDTH]);

  always_ff @(posedge clock) begin
    if (rst) begin
      corr_enable <= 1'b0;
      ook_enable <= 1'b0;
      discriminator_bandwidth <= 8'h00;
      discriminator_phase_select <= 2'h0;
    end else begin
      corr_enable <= in_receive && is_corr;
      ook_enable <= in_receive && is_ook;
      discriminator_bandwidth <= disc_bw_r;
      discriminator_phase_select <= phase_r[`FOD_F_PHASE];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Post-demodulator filter: two cascaded first-order sections

  logic signed [11:0] fin;
  logic signed [11:0] f_r [0:1];
  logic [2:0] f_sh;

  assign fin = is_ook ? $signed({1'b0, rssi_level, 3'h0}) : $signed({disc_sample, 4'h0});
  assign f_sh = bw_shift(postf_r);

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_stage
      logic signed [11:0] s_in;
      logic signed [12:0] s_d;
      if (gi == 0) begin : g_first
        assign s_in = fin;
      end else begin : g_next
        assign s_in = f_r[gi - 1];
      end
      assign s_d = {s_in[11], s_in} - {f_r[gi][11], f_r[gi]};
      always_ff @(posedge clock) begin
        if (rst || !in_receive) f_r[gi] <= 12'sh000;
        else f_r[gi] <= f_r[gi] + 12'(s_d >>> f_sh);
      end
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (rst) filt_out <= 8'sh00;
    else filt_out <= f_r[1][11:4];
  end

  ////////////////////////////////////////////////////////////////////////
  // Lock state machine

  fod_lock_t lk_r;
  fod_lock_t lk_nxt;
  logic [5:0] wait_r;
  logic arm;
  logic cdr_stb;

  assign arm = in_receive && (afc_mode == FOD_AFC_LOCK);

  always_comb begin
    lk_nxt = lk_r;
    case (lk_r)
      LK_OPEN: begin
        if (pre_en && preamble_found) lk_nxt = LK_PRE;
        else if (!pre_en && sync_found) lk_nxt = LK_PKT;
      end
      LK_PRE: begin
        if (sync_found) lk_nxt = LK_PKT;
        else if (preamble_done) lk_nxt = LK_WAIT;
      end
      LK_WAIT: begin
        if (sync_found) lk_nxt = LK_PKT;
        else if (wait_r == `FOD_SYNC_WAIT_BITS) lk_nxt = LK_OPEN;
      end
      LK_PKT: begin
        if (!sport_mode && packet_done) lk_nxt = LK_OPEN;
      end
      default: lk_nxt = LK_OPEN;
    endcase
    // Leaving receive or restarting it always drops the lock
    if (!arm || enter_receive_command) lk_nxt = LK_OPEN;
  end

  always_ff @(posedge clock) begin
    if (rst) lk_r <= LK_OPEN;
    else lk_r <= lk_nxt;
  end

  // Sync window measured in recovered bits after the preamble ends
  always_ff @(posedge clock) begin
    if (rst || lk_r != LK_WAIT) wait_r <= 6'h00;
    else if (cdr_stb && wait_r != `FOD_SYNC_WAIT_BITS) wait_r <= wait_r + 6'h01;
  end

  always_ff @(posedge clock) begin
    if (rst) afc_locked <= 1'b0;
    else afc_locked <= (lk_nxt != LK_OPEN);
  end

  ////////////////////////////////////////////////////////////////////////
  // Frequency correction loop

  logic afc_run;
  logic afc_clear;

  // In correlator mode, hold mode and a taken lock leave both run and clear low
  assign afc_run = in_receive && is_corr &&
                   ((afc_mode == FOD_AFC_FREE) ||
                    (afc_mode == FOD_AFC_LOCK && !afc_locked));
  assign afc_clear = (afc_mode == FOD_AFC_OFF) || !is_corr;

  fod_pi_loop u_pi (
    .clock(clock),
    .rst(rst),
    .run(afc_run),
    .clear(afc_clear),
    .err(f_r[1][11:4]),
    .ki(ki),
    .kp(kp),
    .limit(pull_limit),
    .offset(lo_offset_khz)
  );

  // Readback saturates to +/-127 (8'h7F and 8'h81); retained outside receive
  always_ff @(posedge clock) begin
    if (rst) ferr_r <= 8'h00;
    else if (in_receive && is_corr && (afc_locked || afc_mode == FOD_AFC_FREE)) begin
      if (lo_offset_khz > 9'sd127) ferr_r <= 8'h7F;
      else if (lo_offset_khz < -9'sd127) ferr_r <= 8'h81;
      else ferr_r <= lo_offset_khz[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // OOK threshold and gain clocking

  logic signed [11:0] thr_r;
  logic signed [12:0] thr_d;
  logic thr_run;
  logic slice;

  assign thr_d = {f_r[1][11], f_r[1]} - {thr_r[11], thr_r};
  assign thr_run = in_receive && is_ook && !afc_locked && (afc_mode != FOD_AFC_HOLD);
  assign slice = (f_r[1] > thr_r);

  // Threshold learns during preamble, then holds once locked
  always_ff @(posedge clock) begin
    if (rst || !is_ook) thr_r <= 12'sh000;
    else if (thr_run) thr_r <= thr_r + 12'(thr_d >>> (4'hF - kp));
  end

  always_ff @(posedge clock) begin
    if (rst) ook_threshold <= 8'h00;
    else ook_threshold <= thr_r[10:3];
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      gain_acquiring <= 1'b1;
      gain_clk_div <= 4'h0;
    end else if (!is_ook) begin
      gain_acquiring <= 1'b1;
      gain_clk_div <= 4'h0;
    end else if (glock_r[`FOD_F_GLOCK] == 2'h3 && afc_locked) begin
      gain_acquiring <= 1'b0;
      gain_clk_div <= agcclk_r[`FOD_F_TRK];
    end else begin
      gain_acquiring <= 1'b1;
      gain_clk_div <= agcclk_r[`FOD_F_ACQ];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Clock and data recovery

  logic cdr_din;
  logic cdr_en;

  assign cdr_en = in_receive && (is_corr || is_ook);
  assign cdr_din = is_ook ? slice : !f_r[1][11];

  fod_cdr u_cdr (
    .clock(clock),
    .rst(rst),
    .enable(cdr_en),
    .din(cdr_din),
    .bit_val(rx_bit),
    .bit_stb(cdr_stb),
    .synced(bit_synced)
  );

  assign rx_bit_strobe = cdr_stb;
endmodule : fod_demod_ctrl
`default_nettype wire

//--- core/fod_pi_loop.sv
// Purpose: Proportional-integral frequency correction loop
// Assumes: err is residual carrier error in kHz
// Notes: Neither run nor clear freezes both integrator and output
`timescale 1ns/1ps
`default_nettype none
module fod_pi_loop (
  input wire logic clock,
  input wire logic rst,
  input wire logic run,
  input wire logic clear,
  input wire logic signed [7:0] err,
  input wire logic [3:0] ki,
  input wire logic [3:0] kp,
  input wire logic [8:0] limit,
  output logic signed [8:0] offset
);
  import fod_pkg::*;
  logic signed [19:0] acc_r;
  logic signed [19:0] err_w;
  logic signed [19:0] i_step;
  logic signed [19:0] p_step;
  logic signed [19:0] lim_w;
  logic signed [19:0] out_w;

  // Clamp used on integrator and output, so neither winds up
  function automatic logic signed [19:0] sat(input logic signed [19:0] v,
                                             input logic signed [19:0] l);
    if (v > l) sat = l;
    else if (v < -l) sat = -l;
    else sat = v;
  endfunction : sat

  assign err_w = {{4{err[7]}}, err, 8'h00};
  assign i_step = err_w >>> (4'hF - ki);
  assign p_step = err_w >>> (4'hF - kp);
  assign lim_w = {3'h0, limit, 8'h00};
  assign out_w = sat(acc_r + p_step, lim_w);

  always_ff @(posedge clock) begin
    if (rst || clear) acc_r <= 20'sh00000;
    else if (run) acc_r <= sat(acc_r + i_step, lim_w);
  end

  always_ff @(posedge clock) begin
    if (rst || clear) offset <= 9'sh000;
    else if (run) offset <= out_w[16:8];
  end
endmodule : fod_pi_loop
`default_nettype wire

//--- core/fod_pkg.sv
// Purpose: Types shared by the receive control block
// Assumes: Nothing
// Notes: Mode encodings follow the register fields
package fod_pkg;
  typedef enum logic [1:0] {
    FOD_AFC_FREE = 2'h0,
    FOD_AFC_OFF = 2'h1,
    FOD_AFC_HOLD = 2'h2,
    FOD_AFC_LOCK = 2'h3
  } fod_afc_mode_t;
  typedef enum {LK_OPEN, LK_PRE, LK_WAIT, LK_PKT} fod_lock_t;
endpackage : fod_pkg

//--- test/fod_demod_ctrl_properties.sv
// Purpose: Port-level properties of the receive control block
// Assumes: Shadow fields follow host writes on the write edge
// Notes: Bound to every instance of the block
`timescale 1ns/1ps
`default_nettype none
`include "fod_cfg.svh"
module fod_demod_ctrl_chk (
  input wire logic clock,
  input wire logic rst,
  input wire logic [9:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic in_receive,
  input wire logic enter_receive_command,
  input wire logic preamble_found,
  input wire logic signed [8:0] lo_offset_khz,
  input wire logic afc_locked,
  input wire logic corr_enable,
  input wire logic [1:0] discriminator_phase_select
);
  logic [1:0] mode_r;
  logic [1:0] sch_r;
  logic [1:0] intermediate_filter_width_r;
  logic pre_r;
  logic [8:0] mag;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock) begin
    if (rst) begin
      mode_r <= 2'h0;
      sch_r <= 2'h0;
      intermediate_filter_width_r <= 2'h0;
      pre_r <= 1'b1;
    end else if (reg_wr) begin
      if (reg_addr == `FOD_A_FLOCK) mode_r <= reg_wdata[1:0];
      if (reg_addr == `FOD_A_DEMOD) sch_r <= reg_wdata[1:0];
      if (reg_addr == `FOD_A_DEMOD) intermediate_filter_width_r <= reg_wdata[7:6];
      if (reg_addr == `FOD_A_PREQ) pre_r <= reg_wdata[7];
    end
  end
  assign mag = lo_offset_khz[8] ? 9'(-lo_offset_khz) : lo_offset_khz;
  function automatic logic [8:0] lim(input logic [1:0] w);
    lim = (w == 2'h0) ? 9'h032 : (w == 2'h1) ? 9'h04B : (w == 2'h2) ? 9'h064 : 9'h096;
  endfunction : lim
  ////////////////////////////////////////////////////////////////////////////
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its slot");
  a_pre_lock: assert property (in_receive && !enter_receive_command && preamble_found
    && mode_r == 2'h3 && pre_r |=> afc_locked) else $error("no lock on preamble");
  a_idle_release: assert property (!in_receive |=> !afc_locked)
    else $error("lock kept outside receive");
  a_rerx_release: assert property (enter_receive_command |=> !afc_locked)
    else $error("lock kept over receive command");
  a_corr_gate: assert property (1'b1 |=> corr_enable == $past(in_receive && sch_r == 2'h0))
    else $error("correction enable wrong");
  a_off_clear: assert property ((in_receive && mode_r == 2'h1) [*3] |-> lo_offset_khz == 9'h000)
    else $error("disabled loop not cleared");
  a_pull_range: assert property (intermediate_filter_width_r == $past(intermediate_filter_width_r, 3) |-> mag <= lim(intermediate_filter_width_r))
    else $error("offset beyond pull-in range");
  a_hold_freeze: assert property ((in_receive && sch_r == 2'h0 && mode_r == 2'h2) [*2]
    |=> $stable(lo_offset_khz)) else $error("held loop moved");
  a_lock_freeze: assert property ((in_receive && sch_r == 2'h0 && afc_locked) [*3]
    |-> $stable(lo_offset_khz)) else $error("locked loop moved");
  a_phase_copy: assert property (reg_wr && reg_addr == `FOD_A_PHASE |=> ##1
    discriminator_phase_select == $past(reg_wdata[1:0], 2)) else $error("phase copy wrong");
  c_locked: cover property (afc_locked && in_receive);
  c_hold: cover property (in_receive && mode_r == 2'h2);
  c_ook_lock: cover property (sch_r == 2'h2 && afc_locked);
endmodule : fod_demod_ctrl_chk
bind fod_demod_ctrl fod_demod_ctrl_chk u_chk (.clock(clock), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .in_receive(in_receive), .enter_receive_command(enter_receive_command),
  .preamble_found(preamble_found), .lo_offset_khz(lo_offset_khz), .afc_locked(afc_locked),
  .corr_enable(corr_enable), .discriminator_phase_select(discriminator_phase_select));
`default_nettype wire

//--- test/fod_tx_model.sv
// Purpose: Remote transmitter as seen through the IF path
// Assumes: One symbol per 16 clocks, error is carrier minus correction
// Notes: Without a carrier the sample word changes every cycle
`timescale 1ns/1ps
`default_nettype none
module fod_tx_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic send,
  input wire logic ook,
  input wire logic signed [7:0] offset,
  input wire logic signed [8:0] lo,
  output logic signed [7:0] disc,
  output logic [7:0] rssi
);
  logic [3:0] ph_r;
  logic bit_r;
  logic [7:0] n_r;
  logic signed [10:0] res;
  // Alternating preamble keeps the recovery loop fed
  always_ff @(posedge clock) begin
    n_r <= rst ? 8'h00 : n_r + 8'h3B;
    ph_r <= (rst || !send) ? 4'h0 : ph_r + 4'h1;
    if (rst || !send) bit_r <= 1'b0;
    else if (ph_r == 4'hF) bit_r <= ~bit_r;
  end
  // 20 kHz deviation stays within the margin left at the widest clamp,
  // so a clamped residual never changes sign and the limit reads exactly
  always_comb begin
    res = 11'(offset) - 11'(lo) + (bit_r ? 11'sd20 : -11'sd20);
    if (!send) disc = n_r;
    else if (res > 11'sd127) disc = 8'sd127;
    else if (res < -11'sd127) disc = -8'sd127;
    else disc = res[7:0];
    rssi = !send ? 8'h08 : !ook ? 8'h80 : bit_r ? 8'hC0 : 8'h10;
  end
endmodule : fod_tx_model
`default_nettype wire

//--- test/testbench.sv
// Purpose: Self-checking bench for the receive control block
// Assumes: Status pulses come from the bench, one cycle each
// Notes: ev bits 0-4: preamble, preamble end, sync, packet end, rx command
`timescale 1ns/1ps
`default_nettype none
`include "fod_cfg.svh"
module testbench;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic in_receive = 1'b0;
  logic sport_mode = 1'b0;
  logic send = 1'b0;
  logic ook = 1'b0;
  logic [4:0] ev = 5'h00;
  logic [9:0] reg_addr = 10'h000;
  logic [7:0] reg_wdata = 8'h00;
  logic signed [7:0] offset = 8'sh00;
  logic [7:0] reg_rdata, rssi, thr, dbw, v1, v2;
  logic signed [7:0] disc, filt;
  logic signed [8:0] lo, lo_s;
  logic afc_locked, corr_enable, ook_enable, gacq, synced, rx_bit, rx_stb;
  logic [1:0] dph;
  logic [3:0] gdiv;
  logic [9:0] ra [9] = '{10'h10F, 10'h110, 10'h112, 10'h113, 10'h115, 10'h116, 10'h117,
    10'h11B, 10'h35B};
  logic [7:0] rv [9] = '{8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h73, 8'h80, 8'h00};
  logic [8:0] lim [3] = '{9'h032, 9'h04B, 9'h064};
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;
  fod_demod_ctrl dut (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .disc_sample(disc),
    .rssi_level(rssi), .in_receive(in_receive), .enter_receive_command(ev[4]),
    .sport_mode(sport_mode), .preamble_found(ev[0]), .preamble_done(ev[1]),
    .sync_found(ev[2]), .packet_done(ev[3]), .lo_offset_khz(lo), .afc_locked(afc_locked),
    .corr_enable(corr_enable), .ook_enable(ook_enable), .discriminator_bandwidth(dbw),
    .discriminator_phase_select(dph), .ook_threshold(thr), .gain_clk_div(gdiv),
    .gain_acquiring(gacq), .rx_bit(rx_bit), .rx_bit_strobe(rx_stb), .bit_synced(synced),
    .filt_out(filt));
  fod_tx_model tx (.clock(clock), .rst(rst), .send(send), .ook(ook), .offset(offset),
    .lo(lo), .disc(disc), .rssi(rssi));
  initial forever #50 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [9:0] a, output logic [7:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  task automatic pulse(input int i);
    @(posedge clock);
    ev[i] <= 1'b1;
    @(posedge clock);
    ev <= 5'h00;
    #1;
  endtask : pulse
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    for (int i = 0; i < 9; i++) begin
      rd(ra[i], v1);
      chk(9'(v1), 9'(rv[i]));
      wr(ra[i], 8'h5A ^ 8'(i));
      rd(ra[i], v1);
      chk(9'(v1), 9'(8'h5A ^ 8'(i)));
      wr(ra[i], rv[i]);
    end
    wr(10'h111, 8'hFF);
    rd(10'h111, v1);
    chk(9'(v1), 9'h000);
    // 40 kbps, 10 kHz deviation: MI 0.5, AFC off, K = floor(200/40) = 5
    // K = 5 at 200 kHz IF: 81.25 rounds to 81, phase 3
    wr(`FOD_A_DISC_BW, 8'h51);
    for (int k = 0; k < 4; k++) begin
      wr(`FOD_A_PHASE, 8'(k));
      step(2);
      chk(9'(dph), 9'(k));
    end
    chk(9'(dbw), 9'h051);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_clamp;
    wr(`FOD_A_GAINS, 8'hFF);
    wr(`FOD_A_POSTF, 8'h10); // 32 kHz, near 0.75 of a 43 kbps rate
    send <= 1'b1;
    in_receive <= 1'b1;
    for (int w = 0; w < 3; w++) begin
      for (int s = 0; s < 2; s++) begin
        wr(`FOD_A_DEMOD, 8'(w << 6));
        offset <= s ? -8'sd120 : 8'sd120;
        step(600);
        chk(lo, s ? -lim[w] : lim[w]);
        chk(9'(filt[7]), 9'(s));
        rd(`FOD_A_FERR, v1);
        chk(9'(v1[7]), 9'(s));
      end
    end
    $display("t_clamp done");
  endtask : t_clamp
  task automatic t_lock;
    wr(`FOD_A_GAINS, 8'h73);
    wr(`FOD_A_FLOCK, 8'h01);
    offset <= 8'sd10;
    step(4);
    chk(lo, 9'h000);
    wr(`FOD_A_FLOCK, 8'h03);
    in_receive <= 1'b0;
    @(posedge clock);
    in_receive <= 1'b1;
    step(160);
    chk(9'(synced), 9'h001);
    v2 = 8'h00;
    repeat (48) begin
      step(1);
      if (rx_stb) v2 = {v2[6:0], rx_bit};
    end
    chk(9'(v2[0] ^ v2[1]), 9'h001);
    pulse(0);
    chk(9'(afc_locked), 9'h001);
    lo_s = lo;
    step(100);
    chk(lo, lo_s);
    pulse(1);
    step(160);
    pulse(2);
    step(640);
    chk(9'(afc_locked), 9'h001);
    pulse(3);
    chk(9'(afc_locked), 9'h000);
    @(posedge clock);
    in_receive <= 1'b0;
    rd(`FOD_A_FERR, v1);
    @(posedge clock);
    in_receive <= 1'b1;
    rd(`FOD_A_FERR, v2);
    chk(9'(v2), 9'(v1));
    pulse(0);
    pulse(1);
    step(320);
    chk(9'(afc_locked), 9'h001);
    step(320);
    chk(9'(afc_locked), 9'h000);
    wr(`FOD_A_PREQ, 8'h00);
    pulse(0);
    chk(9'(afc_locked), 9'h000);
    pulse(2);
    step(640);
    chk(9'(afc_locked), 9'h001);
    @(posedge clock);
    sport_mode <= 1'b1;
    pulse(3);
    chk(9'(afc_locked), 9'h001);
    pulse(4);
    chk(9'(afc_locked), 9'h000);
    pulse(2);
    @(posedge clock);
    in_receive <= 1'b0;
    step(1);
    chk(9'(afc_locked), 9'h000);
    @(posedge clock);
    in_receive <= 1'b1;
    sport_mode <= 1'b0;
    $display("t_lock done");
  endtask : t_lock
  task automatic t_modes;
    wr(`FOD_A_PREQ, 8'h80);
    wr(`FOD_A_FLOCK, 8'h00);
    offset <= 8'sd60;
    step(300);
    wr(`FOD_A_FLOCK, 8'h02);
    step(2);
    lo_s = lo;
    step(200);
    chk(lo, lo_s);
    wr(`FOD_A_FLOCK, 8'h00);
    wr(`FOD_A_DEMOD, 8'h02);
    step(4);
    chk({7'h00, corr_enable, ook_enable}, 9'h001);
    chk(lo, 9'h000);
    $display("t_modes done");
  endtask : t_modes
  task automatic t_ook;
    wr(`FOD_A_GAINS, 8'h78);
    wr(`FOD_A_AGCCLK, 8'h94);
    wr(`FOD_A_GLOCK, 8'h03);
    wr(`FOD_A_FLOCK, 8'h03);
    ook <= 1'b1;
    step(4);
    chk({4'h0, gacq, gdiv}, 9'h014);
    step(2000);
    chk(9'((thr > 8'h40) && (thr < 8'h90)), 9'h001);
    pulse(0);
    step(2);
    chk({4'h0, gacq, gdiv}, 9'h009);
    v1 = thr;
    step(200);
    chk(9'(thr), 9'(v1));
    $display("t_ook done");
  endtask : t_ook
  ////////////////////////////////////////////////////////////////////////////
  // Whole run is near 9000 cycles, so the ceiling leaves ample margin
  always @(posedge clock) begin
    cyc++;
    if (cyc == 25000) begin
      errors++;
      give_verdict();
    end
  end
  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    t_regs();
    t_clamp();
    t_lock();
    t_modes();
    t_ook();
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
